// ===== hdl/evtimer_pkg.sv
// shared constants, field layout and state types of the triggered event window pulse timer
package evtimer_pkg;
  localparam int DATA_W = 32;
  localparam int ADR_W = 4;
  localparam int CNT_W = 16;
  localparam int PRESC_W = 11;

  // register byte offsets
  localparam logic [3:0] OFS_CTL = 4'h0;
  localparam logic [3:0] OFS_CMP = 4'h4;
  localparam logic [3:0] OFS_CAP = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hc;

  // control register field positions, and the run flag position of the status register
  localparam int MODE_LSB = 0;
  localparam int CK_LSB = 2;
  localparam int START_LSB = 4;
  localparam int OPT_BIT = 6;
  localparam int RUN_BIT = 16;

  // field encodings
  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_WINDOW = 2'h1;
  localparam logic [1:0] MODE_PULSE = 2'h2;
  localparam logic [1:0] CK_PIN = 2'h3;
  localparam logic [1:0] START_STOP = 2'h0;
  localparam logic [1:0] START_CMD = 2'h1;
  localparam logic [1:0] START_RISE = 2'h2;

  // prescaler tap masks: divide by 2^11, 2^7, 2^3
  localparam logic [10:0] TAP_MASK_0 = 11'h7ff;
  localparam logic [10:0] TAP_MASK_1 = 11'h07f;
  localparam logic [10:0] TAP_MASK_2 = 11'h007;

  // reset values
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [15:0] CAP_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;

  // input noise filter timing, in periods of the 40 MHz clock
  localparam int REJECT_CYC = 4;
  localparam int ACCEPT_CYC = 12;
  localparam int FILT_CYC = (REJECT_CYC + ACCEPT_CYC) / 2;

  typedef enum logic {RUN_IDLE, RUN_COUNT} run_e;

  typedef struct packed {
    logic [7:0] ctl;
    logic [15:0] cmp;
    logic [15:0] cap;
    logic [15:0] cnt;
    run_e run;
    logic pin_q;
    logic [10:0] presc;
    logic ack;
    logic [31:0] rdat;
    logic irq;
  } timer_s;

  localparam timer_s TIMER_RST = '{ctl: CTL_RST, cmp: CMP_RST, cap: CAP_RST, cnt: CNT_RST,
                                   run: RUN_IDLE, pin_q: 1'b0, presc: 11'h000, ack: 1'b0,
                                   rdat: 32'h0000_0000, irq: 1'b0};

  typedef struct packed {
    logic lvl;
    logic [3:0] cnt;
  } filt_s;

  localparam filt_s FILT_RST = '{lvl: 1'b0, cnt: 4'h0};
endpackage

// ===== hdl/pin_noise_filter.sv
// noise filter for the timer input pin, bypassed in low-speed and sleep modes
`timescale 1ns/10ps
`default_nettype none
module pin_noise_filter
  import evtimer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic pin_i,
  input wire logic bypass_i,
  output logic level_o
);
  filt_s st_r;
  filt_s st_nxt;

  // a change must persist for FILT_CYC cycles; short glitches reset the count
  always_comb
  begin
    st_nxt = st_r;
    if (bypass_i)
    begin
      st_nxt.lvl = pin_i;
      st_nxt.cnt = 4'h0;
    end
    else if (pin_i == st_r.lvl)
    begin
      st_nxt.cnt = 4'h0;
    end
    else if (st_r.cnt == 4'(FILT_CYC - 1))
    begin
      st_nxt.lvl = pin_i;
      st_nxt.cnt = 4'h0;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_r <= FILT_RST;
    else if (ce_i)
      st_r <= st_nxt;
  end

  assign level_o = st_r.lvl;

  default clocking fcb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // a pulse of REJECT_CYC cycles never reaches the output
  short_reject_a: assert property (ce_i && !bypass_i && st_r.cnt == 4'h0 && pin_i != st_r.lvl ##1
    (ce_i && pin_i != st_r.lvl) [*3] ##1 (ce_i && pin_i == st_r.lvl && !bypass_i) |=> st_r.cnt == 4'h0)
    else $error("short pulse not rejected");
endmodule
`default_nettype wire

// ===== hdl/evtimer.sv
// triggered event window pulse timer with a classic wishbone register slave
// Notes on behaviour
// - external trigger mode waits idle for selected edge, then counts source clock ticks
// - external trigger compare match clears and halts counter and raises request
// - trigger-stop set: opposite edge before match clears and halts, no request
// - trigger-stop set: after halt, next trigger edge restarts counting from zero
// - trigger-stop clear: opposite edge ignored, trigger edge during count ignored
// - pin filter drops pulses up to 4/fc; source gives at least 12/fc
// - filter bypassed in low-speed and sleep modes; pulses still one machine cycle
// - event counter increments on each selected pin edge, not internal clock
// - event match checked at opposite edge; then request, clear, keep counting
// - auto-capture copies counter to capture register on each counter tick
// - window mode counts source ticks while pin is at selected level
// - window mode match raises request and clears counter
// - single-edge capture: opposite edge captures, requests, sets counter to one; restart on trigger
// - double-edge: capture at both edges; trigger edge also clears and continues
// - after single-edge capture counter rests at one until next trigger edge
// - stop power mode forces start field to 00 and halts the timer
`timescale 1ns/10ps
`default_nettype none
module evtimer
  import evtimer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [evtimer_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [evtimer_pkg::DATA_W-1:0] wb_dat_i,
  output logic [evtimer_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic timer_input_pin_i,
  input wire logic low_speed_modes_i,
  input wire logic sleep_modes_i,
  input wire logic stop_mode_i,
  output logic timer_match_irq_o
);
  timer_s st_r;
  timer_s st_nxt;
  logic filt_lvl;
  logic [1:0] mode;
  logic [1:0] src_sel;
  logic [1:0] start_edge_ctl;
  logic opt_bit;
  logic rise;
  logic fall;
  logic trig_edge;
  logic opp_edge;
  logic src_tick;
  logic cnt_tick;
  logic win_level;
  logic match;
  logic event_mode;
  logic plain_mode;
  logic ett_mode;
  logic capture_on;
  logic [31:0] rd_data;

  // tick of the selected prescaler tap; pin source gives no internal tick
  function automatic logic tap_tick(input logic [10:0] p, input logic [1:0] sel);
    logic t;
    t = 1'b0;
    unique case (sel)
      2'h0: t = ((p & TAP_MASK_0) == TAP_MASK_0);
      2'h1: t = ((p & TAP_MASK_1) == TAP_MASK_1);
      2'h2: t = ((p & TAP_MASK_2) == TAP_MASK_2);
      2'h3: t = 1'b0;
    endcase
    return t;
  endfunction

  // filter is off in the slow modes, where its delay would eat the pulse
  pin_noise_filter u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(timer_input_pin_i),
    .bypass_i(low_speed_modes_i | sleep_modes_i),
    .level_o(filt_lvl)
  );

  // control field decode
  assign mode = st_r.ctl[MODE_LSB +: 2];
  assign src_sel = st_r.ctl[CK_LSB +: 2];
  assign start_edge_ctl = st_r.ctl[START_LSB +: 2];
  assign opt_bit = st_r.ctl[OPT_BIT];

  // edges of the filtered pin; start field low bit picks falling as trigger
  assign rise = filt_lvl & ~st_r.pin_q;
  assign fall = ~filt_lvl & st_r.pin_q;
  assign trig_edge = start_edge_ctl[0] ? fall : rise;
  assign opp_edge = start_edge_ctl[0] ? rise : fall;
  assign src_tick = tap_tick(st_r.presc, src_sel);
  assign cnt_tick = (src_sel == CK_PIN) ? trig_edge : src_tick;
  assign win_level = start_edge_ctl[0] ? ~filt_lvl : filt_lvl;
  assign match = (st_r.cnt == st_r.cmp);

  // sub-mode decode of the shared timer mode code
  assign event_mode = (mode == MODE_TIMER) && (src_sel == CK_PIN);
  assign plain_mode = (mode == MODE_TIMER) && !event_mode && (start_edge_ctl == START_CMD);
  assign ett_mode = (mode == MODE_TIMER) && !event_mode && start_edge_ctl[1];
  assign capture_on = opt_bit && ((mode == MODE_TIMER && !ett_mode) || mode == MODE_WINDOW);

  // read mux, registered into rdat when the access is acknowledged
  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      OFS_CTL: rd_data = {24'h00_0000, st_r.ctl};
      OFS_CMP: rd_data = {16'h0000, st_r.cmp};
      OFS_CAP: rd_data = {16'h0000, st_r.cap};
      OFS_STAT: rd_data = {15'h0000, (st_r.run == RUN_COUNT), st_r.cnt};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // next state: bus access, power-mode stop, then the counting engine
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.irq = 1'b0;
    st_nxt.ack = 1'b0;
    st_nxt.pin_q = filt_lvl;
    st_nxt.presc = st_r.presc + 11'h001;
    if (wb_cyc_i && wb_stb_i && !st_r.ack)
    begin
      st_nxt.ack = 1'b1;
      st_nxt.rdat = rd_data;
      if (wb_we_i)
      begin
        if (wb_adr_i == OFS_CTL && wb_sel_i[0])
          st_nxt.ctl = wb_dat_i[7:0];
        if (wb_adr_i == OFS_CMP && wb_sel_i[0])
          st_nxt.cmp[7:0] = wb_dat_i[7:0];
        if (wb_adr_i == OFS_CMP && wb_sel_i[1])
          st_nxt.cmp[15:8] = wb_dat_i[15:8];
      end
    end
    if (stop_mode_i)
      st_nxt.ctl[START_LSB +: 2] = START_STOP;
    if (start_edge_ctl == START_STOP)
    begin
      // stopped: counter held at zero so the next start begins clean
      st_nxt.cnt = CNT_RST;
      st_nxt.run = RUN_IDLE;
    end
    else if (event_mode)
    begin
      if (opp_edge && match)
      begin
        st_nxt.irq = 1'b1;
        st_nxt.cnt = CNT_RST;
      end
      else if (cnt_tick)
        st_nxt.cnt = st_r.cnt + 16'h0001;
      if (capture_on && cnt_tick)
        st_nxt.cap = st_r.cnt;
    end
    else if (plain_mode || mode == MODE_WINDOW)
    begin
      // plain timer shares the match path with window; window gates by pin
      if (match)
      begin
        st_nxt.irq = 1'b1;
        st_nxt.cnt = CNT_RST;
      end
      else if (cnt_tick && (plain_mode || win_level))
        st_nxt.cnt = st_r.cnt + 16'h0001;
      if (capture_on && cnt_tick)
        st_nxt.cap = st_r.cnt;
    end
    else if (ett_mode)
    begin
      unique case (st_r.run)
        RUN_IDLE:
        begin
          if (trig_edge)
          begin
            st_nxt.run = RUN_COUNT;
            st_nxt.cnt = CNT_RST;
          end
        end
        RUN_COUNT:
        begin
          // trigger edges are ignored here whatever the stop option says
          if (match)
          begin
            st_nxt.irq = 1'b1;
            st_nxt.cnt = CNT_RST;
            st_nxt.run = RUN_IDLE;
          end
          else if (opt_bit && opp_edge)
          begin
            st_nxt.cnt = CNT_RST;
            st_nxt.run = RUN_IDLE;
          end
          else if (src_tick)
            st_nxt.cnt = st_r.cnt + 16'h0001;
        end
      endcase
    end
    else if (mode == MODE_PULSE)
    begin
      unique case (st_r.run)
        RUN_IDLE:
        begin
          // the count left from a single-edge capture is kept, so it resumes at one
          if (trig_edge)
            st_nxt.run = RUN_COUNT;
        end
        RUN_COUNT:
        begin
          if (opp_edge)
          begin
            st_nxt.cap = st_r.cnt;
            st_nxt.irq = 1'b1;
            if (opt_bit)
            begin
              st_nxt.cnt = 16'h0001;
              st_nxt.run = RUN_IDLE;
            end
            else if (src_tick)
              st_nxt.cnt = st_r.cnt + 16'h0001;
          end
          else if (trig_edge && !opt_bit)
          begin
            st_nxt.cap = st_r.cnt;
            st_nxt.irq = 1'b1;
            st_nxt.cnt = CNT_RST;
          end
          else if (src_tick)
            st_nxt.cnt = st_r.cnt + 16'h0001;
        end
      endcase
    end
  end

  // all state advances only while the clock enable is high
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_r <= TIMER_RST;
    else if (ce_i)
      st_r <= st_nxt;
  end

  assign wb_dat_o = st_r.rdat;
  assign wb_ack_o = st_r.ack;
  assign timer_match_irq_o = st_r.irq;

  default clocking tcb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req_acked;
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o ##1 wb_ack_o;
  endsequence

  sequence s_ack_dropped;
    ce_i ##1 !wb_ack_o;
  endsequence

  bus_ack_pulse_a: assert property (s_req_acked |-> s_ack_dropped)
    else $error("ack held longer than one cycle");

  stop_forces_a: assert property (ce_i && stop_mode_i |=> start_edge_ctl == START_STOP)
    else $error("stop mode did not clear start field");

  ett_match_halt_a: assert property (ce_i && ett_mode && st_r.run == RUN_COUNT && match
    |=> timer_match_irq_o && st_r.run == RUN_IDLE && st_r.cnt == 16'h0000)
    else $error("trigger timer match did not halt with request");

  ett_abort_a: assert property (ce_i && ett_mode && opt_bit && st_r.run == RUN_COUNT && opp_edge && !match
    |=> !timer_match_irq_o && st_r.run == RUN_IDLE && st_r.cnt == 16'h0000)
    else $error("opposite edge did not abort silently");

  ett_ignore_a: assert property (ce_i && ett_mode && !opt_bit && st_r.run == RUN_COUNT && !match && !src_tick
    |=> st_r.run == RUN_COUNT && $stable(st_r.cnt))
    else $error("edge disturbed running trigger count");

  event_match_a: assert property (ce_i && event_mode && start_edge_ctl != START_STOP && opp_edge && match
    |=> timer_match_irq_o && st_r.cnt == 16'h0000)
    else $error("event match not cleared at opposite edge");

  autocapture_copy_a: assert property (ce_i && capture_on && cnt_tick && start_edge_ctl != START_STOP
    |=> st_r.cap == $past(st_r.cnt))
    else $error("auto-capture missed a tick");

  window_gate_a: assert property (ce_i && mode == MODE_WINDOW && start_edge_ctl != START_STOP && !win_level
    && !match |=> $stable(st_r.cnt))
    else $error("window counted outside its level");

  single_capture_a: assert property (ce_i && mode == MODE_PULSE && opt_bit && start_edge_ctl != START_STOP
    && st_r.run == RUN_COUNT && opp_edge |=> timer_match_irq_o && st_r.cap == $past(st_r.cnt) && st_r.cnt == 16'h0001)
    else $error("single-edge capture wrong");
endmodule
`default_nettype wire

// ===== sim/pulse_source.sv
// behavioural external pulse source that drives the timer input pin
`timescale 1ns/10ps
`default_nettype none
module pulse_source (
  input wire logic clk_i,
  output logic pin_o
);
  // the pin is pushed, never released, so it always shows a real level
  initial pin_o = 1'b0;

  // level launched after an edge and held for cyc edges; short holds only when a test asks for them
  task automatic drive(input logic lvl, input int cyc);
    pin_o <= lvl;
    repeat (cyc) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ===== sim/evtimer_tb_top.sv
// self-checking bench for the event timer
`timescale 1ns/10ps
`default_nettype none
module evtimer_tb_top;
  import evtimer_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic pin;
  logic slow = 1'b0;
  logic sleep = 1'b0;
  logic stop = 1'b0;
  logic ce = 1'b1;
  logic irq;
  logic [31:0] q;
  logic [31:0] q2;
  int fail_count = 0;
  int checked = 0;
  int irqs = 0;
  int n;

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  // request pulses last one cycle, so count them as they pass
  always @(posedge clk_i)
    if (irq === 1'b1)
      irqs <= irqs + 1;

  evtimer u_evtimer (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .timer_input_pin_i(pin), .low_speed_modes_i(slow), .sleep_modes_i(sleep), .stop_mode_i(stop),
    .timer_match_irq_o(irq));

  pulse_source u_pulse_source (.clk_i(clk_i), .pin_o(pin));

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // range compare, for figures that depend on prescaler phase
  task automatic rng(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    chk({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask

  // one classic cycle; held until ack is sampled, answer taken at that edge
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
    begin
      fail_count++;
      $display("bus answer missing at %0t", $time);
      wrap_up();
    end
  endtask

  // mode fields are changed only while stopped, then the start field is set
  // compare is always programmed above one
  task automatic setup(input logic [1:0] m, s, st, input logic o, input logic [15:0] c);
    xfer(1'b1, OFS_CTL, {25'h0, o, START_STOP, s, m});
    xfer(1'b1, OFS_CMP, {16'h0, c});
    xfer(1'b1, OFS_CTL, {25'h0, o, st, s, m});
  endtask

  // bounded wait for the next request; n holds the cycles spent
  task automatic wait_irq(input int lim);
    int base;
    base = irqs;
    n = 0;
    while (irqs == base && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
    if (irqs == base)
    begin
      fail_count++;
      $display("no request by %0t", $time);
      wrap_up();
    end
  endtask

  task automatic t_regs();
    xfer(1'b0, OFS_CTL, 32'h0);
    chk(q, {24'h0, CTL_RST});
    xfer(1'b0, OFS_CAP, 32'h0);
    chk(q, {16'h0, CAP_RST});
    xfer(1'b0, OFS_STAT, 32'h0);
    chk(q, {16'h0, CNT_RST});
    xfer(1'b1, OFS_CMP, 32'hffff_abcd);
    xfer(1'b0, OFS_CMP, 32'h0);
    chk(q, 32'h0000_abcd);
    xfer(1'b1, OFS_CAP, 32'h1234);
    xfer(1'b0, OFS_CAP, 32'h0);
    chk(q, 32'h0);
    xfer(1'b1, 4'h2, 32'h55);
    xfer(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_trigger();
    setup(MODE_TIMER, 2'h2, START_RISE, 1'b0, 16'h0005);
    u_pulse_source.drive(1'b1, 3);
    u_pulse_source.drive(1'b0, 30);
    xfer(1'b0, OFS_STAT, 32'h0);
    chk(q, 32'h0);
    // short pulses pass once the filter is bypassed, by either mode
    for (int k = 0; k < 2; k++)
    begin
      slow <= (k == 0);
      sleep <= (k == 1);
      u_pulse_source.drive(1'b1, 2);
      u_pulse_source.drive(1'b0, 1);
      wait_irq(100);
      xfer(1'b0, OFS_STAT, 32'h0);
      chk(q, 32'h0);
    end
    slow <= 1'b0;
    sleep <= 1'b0;
    // fall and a second rise during the count change nothing
    u_pulse_source.drive(1'b1, 12);
    u_pulse_source.drive(1'b0, 12);
    u_pulse_source.drive(1'b1, 12);
    wait_irq(100);
    rng(n, 1, 20);
    u_pulse_source.drive(1'b0, 20);
    $display("test trigger done");
  endtask

  task automatic t_trig_stop();
    int b;
    setup(MODE_TIMER, 2'h2, START_RISE, 1'b1, 16'h0100);
    b = irqs;
    u_pulse_source.drive(1'b1, 40);
    u_pulse_source.drive(1'b0, 40);
    chk(irqs, b);
    xfer(1'b0, OFS_STAT, 32'h0);
    chk(q, 32'h0);
    u_pulse_source.drive(1'b1, 40);
    xfer(1'b0, OFS_STAT, 32'h0);
    chk(q[16], 1'b1);
    rng(q[15:0], 1, 8);
    u_pulse_source.drive(1'b0, 20);
    $display("test trigger stop done");
  endtask

  task automatic t_event();
    int b;
    setup(MODE_TIMER, CK_PIN, START_RISE, 1'b1, 16'h0003);
    repeat (2)
    begin
      u_pulse_source.drive(1'b1, 16);
      u_pulse_source.drive(1'b0, 16);
    end
    xfer(1'b0, OFS_STAT, 32'h0);
    chk(q[15:0], 16'h0002);
    xfer(1'b0, OFS_CAP, 32'h0);
    rng(q, 1, 2);
    b = irqs;
    u_pulse_source.drive(1'b1, 16);
    chk(irqs, b);
    u_pulse_source.drive(1'b0, 1);
    wait_irq(30);
    repeat (10) @(posedge clk_i);
    xfer(1'b0, OFS_STAT, 32'h0);
    chk(q[15:0], 16'h0000);
    u_pulse_source.drive(1'b1, 16);
    xfer(1'b0, OFS_STAT, 32'h0);
    chk(q[15:0], 16'h0001);
    u_pulse_source.drive(1'b0, 16);
    $display("test event done");
  endtask

  task automatic t_window();
    for (int st = 2; st < 4; st++)
    begin
      u_pulse_source.drive(st == 3, 20);
      setup(MODE_WINDOW, 2'h2, st[1:0], 1'b0, 16'h0004);
      repeat (64) @(posedge clk_i);
      xfer(1'b0, OFS_STAT, 32'h0);
      chk(q[15:0], 16'h0000);
      u_pulse_source.drive(st == 2, 1);
      wait_irq(100);
      rng(n, 24, 50);
    end
    // plain command start counts at once on the divide-by-8 tap
    setup(MODE_TIMER, 2'h2, START_CMD, 1'b0, 16'h0004);
    wait_irq(100);
    rng(n, 24, 40);
    $display("test window done");
  endtask

  // 80 cycles is a whole number of divide-by-8 ticks, so captures are exact
  task automatic t_single();
    setup(MODE_PULSE, 2'h2, START_RISE, 1'b1, 16'hffff);
    u_pulse_source.drive(1'b1, 80);
    u_pulse_source.drive(1'b0, 1);
    wait_irq(30);
    xfer(1'b0, OFS_CAP, 32'h0);
    q2 = q;
    rng(q2, 8, 12);
    xfer(1'b0, OFS_STAT, 32'h0);
    chk(q, 32'h1);
    repeat (60) @(posedge clk_i);
    u_pulse_source.drive(1'b1, 80);
    u_pulse_source.drive(1'b0, 1);
    wait_irq(30);
    xfer(1'b0, OFS_CAP, 32'h0);
    chk(q, q2 + 32'h1);
    $display("test single edge done");
  endtask

  task automatic t_double();
    int b;
    repeat (40) @(posedge clk_i);
    setup(MODE_PULSE, 2'h2, START_RISE, 1'b0, 16'hffff);
    b = irqs;
    u_pulse_source.drive(1'b1, 80);
    u_pulse_source.drive(1'b0, 40);
    chk(irqs, b + 1);
    xfer(1'b0, OFS_CAP, 32'h0);
    q2 = q;
    u_pulse_source.drive(1'b1, 1);
    wait_irq(30);
    xfer(1'b0, OFS_CAP, 32'h0);
    rng(q - q2, 4, 8);
    xfer(1'b0, OFS_STAT, 32'h0);
    chk(q[16], 1'b1);
    rng(q[15:0], 0, 3);
    // clock enable low must freeze the running count
    q2 = q;
    ce <= 1'b0;
    repeat (40) @(posedge clk_i);
    ce <= 1'b1;
    xfer(1'b0, OFS_STAT, 32'h0);
    rng(q[15:0] - q2[15:0], 0, 1);
    $display("test double edge done");
  endtask

  task automatic t_stop();
    @(posedge clk_i);
    stop <= 1'b1;
    @(posedge clk_i);
    stop <= 1'b0;
    xfer(1'b0, OFS_CTL, 32'h0);
    chk(q, {25'h0, 1'b0, START_STOP, 2'h2, MODE_PULSE});
    xfer(1'b0, OFS_STAT, 32'h0);
    chk(q, 32'h0);
    $display("test stop mode done");
  endtask

  // reset, then the scenarios in order
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_trigger();
    t_trig_stop();
    t_event();
    t_window();
    t_single();
    t_double();
    t_stop();
    wrap_up();
  end
endmodule
`default_nettype wire
